// *** verilog/aca_map.svh ***
// Register offsets, field positions, result codes, reset values and timing limits
`ifndef ACA_MAP_SVH
`define ACA_MAP_SVH
// Task-file register offsets
`define ACA_OFS_SECCNT 4'h2
`define ACA_OFS_DRVHEAD 4'h6
`define ACA_OFS_CMD 4'h7
`define ACA_OFS_STATUS 4'h7
`define ACA_OFS_ERROR 4'h1
`define ACA_OFS_ALTSTAT 4'hE
`define ACA_OFS_DRVADDR 4'hF
// Drive/head fields
`define ACA_DH_DRV 4
`define ACA_DH_HEAD_HI 3
// Readback fields
`define ACA_RB_WGATE 6
`define ACA_RB_HEAD_HI 5
`define ACA_RB_HEAD_LO 2
`define ACA_RB_DS1 1
`define ACA_RB_DS0 0
// Status fields
`define ACA_ST_BUSY 7
`define ACA_ST_RDY 6
`define ACA_ST_DSC 4
`define ACA_ST_DRQ 3
`define ACA_ST_ERR 0
// Power query answers
`define ACA_PWR_SLEEP 8'h00
`define ACA_PWR_IDLE 8'hFF
// Diagnostic codes
`define ACA_DIAG_OK 8'h01
`define ACA_DIAG_FMT 8'h02
`define ACA_DIAG_BUF 8'h03
`define ACA_DIAG_ECC 8'h04
`define ACA_DIAG_CPU 8'h05
`define ACA_DIAG_SLAVE 8'h80
// Reset values
`define ACA_RST_DRVHEAD 8'hA0
`define ACA_RST_SECCNT 8'h01
`define ACA_RST_ERROR 8'h01
// Timing
`define ACA_CLK_NS 8
`define ACA_BUSY_MAX_NS 400
`define ACA_DRQ2_MAX_US 700
`define ACA_DRQ3_MAX_MS 20
`endif

// *** verilog/aca_pkg.sv ***
// Types shared by the command acceptance block
package aca_pkg;
   typedef enum logic [2:0] {
      ACA_CLS_NONE = 3'b000, // Not a recognised code
      ACA_CLS_1 = 3'b001, // Busy until engine done (power query goes straight to done), reads then DRQ
      ACA_CLS_2 = 3'b010, // Busy then DRQ, short wait
      ACA_CLS_3 = 3'b011 // Busy then DRQ, long wait
   } aca_class_e;
   typedef enum logic [2:0] {
      ACA_OP_PLAIN = 3'b000, // Handed to command engine
      ACA_OP_PWRCHK = 3'b001, // Power mode query
      ACA_OP_DIAG = 3'b010, // Self diagnostic
      ACA_OP_READ = 3'b011, // Read-type transfer
      ACA_OP_WRITE = 3'b100 // Write-type transfer
   } aca_op_e;
   typedef enum logic [2:0] {
      ACA_ST_IDLE = 3'b000, // Waiting for command
      ACA_ST_EXEC = 3'b001, // Busy, engine running
      ACA_ST_PREP = 3'b010, // Busy, buffer setup
      ACA_ST_XFER = 3'b011, // DRQ, host moving data
      ACA_ST_DONE = 3'b100 // Result posting
   } aca_state_e;
endpackage

// *** verilog/aca_decode.sv ***
// Command code decoder into acceptance class and operation
`timescale 1ns/10ps
module aca_decode
   import aca_pkg::*;
(
   input wire logic [7:0] code_in, // Command code
   output aca_class_e class_out, // Acceptance class
   output aca_op_e op_out, // Operation kind
   output logic drive_only_out // Head field ignored
);
   // Pure table lookup; unknown codes give class none
   always_comb begin
      class_out = ACA_CLS_NONE;
      op_out = ACA_OP_PLAIN;
      drive_only_out = 1'b0;
      unique casez (code_in)
         8'h20, 8'h21, 8'hC4, 8'h40, 8'h41, 8'h22, 8'h23: begin
            class_out = ACA_CLS_1;
            op_out = ACA_OP_READ;
         end
         8'hE4, 8'hEC: begin
            class_out = ACA_CLS_1;
            op_out = ACA_OP_READ;
            drive_only_out = 1'b1;
         end
         8'h30, 8'h31, 8'h38, 8'h3C, 8'h32, 8'h33, 8'h50: begin
            class_out = ACA_CLS_2;
            op_out = ACA_OP_WRITE;
         end
         8'hE8: begin
            class_out = ACA_CLS_2;
            op_out = ACA_OP_WRITE;
            drive_only_out = 1'b1;
         end
         8'hC5, 8'hCD: begin
            class_out = ACA_CLS_3;
            op_out = ACA_OP_WRITE;
         end
         8'h90: begin
            class_out = ACA_CLS_1;
            op_out = ACA_OP_DIAG;
            drive_only_out = 1'b1;
         end
         8'hE5, 8'h98: begin
            class_out = ACA_CLS_1;
            op_out = ACA_OP_PWRCHK;
            drive_only_out = 1'b1;
         end
         8'h91, 8'h7?, 8'hC0, 8'h87, 8'hF5: begin
            class_out = ACA_CLS_1;
         end
         8'h1?, 8'hEF, 8'hC6, 8'h03, 8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE6,
         8'h94, 8'h95, 8'h96, 8'h97, 8'h99: begin
            class_out = ACA_CLS_1;
            drive_only_out = 1'b1;
         end
         default: begin // Unrecognised code
            class_out = ACA_CLS_NONE;
         end
      endcase
   end
endmodule

// *** verilog/aca_core.sv ***
// Command acceptance, status sequencing and drive address readback
`timescale 1ns/10ps
`include "aca_map.svh"
module aca_core
   import aca_pkg::*;
#(
   parameter int DRQ2_CYC = (`ACA_DRQ2_MAX_US * 1000) / `ACA_CLK_NS, // Class 2 DRQ limit
   parameter int DRQ3_CYC = (`ACA_DRQ3_MAX_MS * 1000000) / `ACA_CLK_NS, // Class 3 DRQ limit
   parameter int PREP_CYC = 16 // Buffer setup time used
)(
   input wire logic clk_in, // System clock 125 MHz
   input wire logic arst_n_in, // Async reset, active low
   input wire logic ce_in, // Clock enable, freezes state
   input wire logic [3:0] addr_in, // Task-file offset
   input wire logic wr_in, // Write strobe, one cycle
   input wire logic rd_in, // Read strobe, one cycle
   input wire logic [7:0] wdata_in, // Write data
   input wire logic drive_id_in, // This card's drive number
   input wire logic sleep_in, // Power state is sleep-related
   input wire logic exec_done_in, // Engine finished command
   input wire logic xfer_done_in, // Host data block moved
   input wire logic [7:0] diag_code_in, // Self test result
   output logic [7:0] rdata_out, // Read data, registered
   output logic busy_out, // Busy status bit
   output logic drq_out, // Data request status bit
   output logic intrq_out, // Pending interrupt
   output logic cmd_start_out, // Pulse to command engine
   output logic [7:0] cmd_code_out, // Accepted command code
   output logic [3:0] head_out, // Head used by command
   output logic wgate_out // Write in progress
);
   localparam int BUSY_CYC = `ACA_BUSY_MAX_NS / `ACA_CLK_NS; // Busy limit in cycles
   localparam int CW = 22; // Counter width

   aca_class_e dec_class; // Decoded class
   aca_op_e dec_op; // Decoded operation
   logic dec_donly; // Drive-only command

   aca_state_e state_q, state_d; // Sequencer state
   aca_op_e op_q, op_d; // Latched operation
   logic [CW-1:0] cnt_q, cnt_d; // Setup timer
   logic [7:0] dh_q, dh_d; // Drive/head register
   logic [7:0] sc_q, sc_d; // Sector count register
   logic [7:0] err_q, err_d; // Error register
   logic [7:0] code_q, code_d; // Accepted code
   logic [3:0] head_q, head_d; // Effective head
   logic start_q, start_d; // Engine start pulse
   logic int_q, int_d; // Interrupt pending
   logic errf_q, errf_d; // Error status flag
   logic [7:0] rdata_q, rdata_d; // Read data latch
   logic busy_q, busy_d; // Busy flag, kept in step with state
   logic drq_q, drq_d; // Data request flag
   logic wg_q, wg_d; // Write gate flag

   // Code table lives in its own module
   aca_decode u_dec (
      .code_in(wdata_in),
      .class_out(dec_class),
      .op_out(dec_op),
      .drive_only_out(dec_donly)
   );

   // Commands are accepted only when this card's drive number is selected
   function automatic logic selected(input logic [7:0] dh, input logic id);
      selected = (dh[`ACA_DH_DRV] == id);
   endfunction

   // Flags come from flops so the pins carry no decode glitches
   wire logic busy_w = busy_q; // Same timing as the state decode
   wire logic drq_w = drq_q;
   wire logic wg_w = wg_q;
   wire logic [7:0] status_w = {busy_w, 1'b1, 1'b0, 1'b1, drq_w, 1'b0, 1'b0, errf_q};

   // Next state for sequencer and task file
   always_comb begin
      state_d = state_q;
      op_d = op_q;
      cnt_d = cnt_q;
      dh_d = dh_q;
      sc_d = sc_q;
      err_d = err_q;
      code_d = code_q;
      head_d = head_q;
      start_d = 1'b0;
      int_d = int_q;
      errf_d = errf_q;
      // Status read clears interrupt; alternate status does not
      if (rd_in && addr_in == `ACA_OFS_STATUS) begin
         int_d = 1'b0;
      end
      // Parameter loads blocked while busy
      if (wr_in && !busy_w) begin
         if (addr_in == `ACA_OFS_DRVHEAD) begin
            dh_d = wdata_in;
         end else if (addr_in == `ACA_OFS_SECCNT) begin
            sc_d = wdata_in;
         end
      end
      unique case (state_q)
         ACA_ST_IDLE: begin
            // Command write while not busy; unknown code aborts
            if (wr_in && addr_in == `ACA_OFS_CMD && selected(dh_q, drive_id_in)) begin
               if (dec_class == ACA_CLS_NONE) begin
                  errf_d = 1'b1;
                  err_d = 8'h04;
                  int_d = 1'b1;
               end else begin
                  // Busy next cycle, far inside 400 ns
                  state_d = (dec_class == ACA_CLS_1) ? ACA_ST_EXEC : ACA_ST_PREP;
                  op_d = dec_op;
                  code_d = wdata_in;
                  errf_d = 1'b0;
                  head_d = dec_donly ? 4'h0 : dh_q[`ACA_DH_HEAD_HI:0];
                  start_d = 1'b1;
                  cnt_d = '0;
               end
            end
         end
         ACA_ST_PREP: begin
            // Buffer setup well below the class limit
            cnt_d = cnt_q + CW'(1);
            if (cnt_q >= CW'(PREP_CYC) || cnt_q >= CW'(DRQ2_CYC - 1) || cnt_q >= CW'(DRQ3_CYC - 1)) begin
               state_d = ACA_ST_XFER; // Busy drops with DRQ rising
            end
         end
         ACA_ST_EXEC: begin
            if (op_q == ACA_OP_PWRCHK) begin
               sc_d = sleep_in ? `ACA_PWR_SLEEP : `ACA_PWR_IDLE;
               state_d = ACA_ST_DONE;
            end else if (op_q == ACA_OP_DIAG && exec_done_in) begin
               err_d = diag_code_in;
               state_d = ACA_ST_DONE;
            end else if (exec_done_in) begin
               state_d = (op_q == ACA_OP_READ) ? ACA_ST_XFER : ACA_ST_DONE;
            end
         end
         ACA_ST_XFER: begin
            // Host moves the block through the data register
            if (xfer_done_in) begin
               state_d = ACA_ST_DONE;
            end
         end
         ACA_ST_DONE: begin
            state_d = ACA_ST_IDLE; // Busy released
            int_d = 1'b1;
            op_d = ACA_OP_PLAIN;
         end
         default: begin
            state_d = ACA_ST_IDLE; // Illegal codes recover
         end
      endcase
      // Decode next state, so the registered flags match state_q
      busy_d = (state_d == ACA_ST_EXEC) || (state_d == ACA_ST_PREP) || (state_d == ACA_ST_DONE);
      drq_d = (state_d == ACA_ST_XFER);
      wg_d = (op_d == ACA_OP_WRITE) && (state_d != ACA_ST_IDLE);
   end

   // Read data mux, registered
   always_comb begin
      rdata_d = 8'h00;
      unique case (addr_in)
         `ACA_OFS_STATUS, `ACA_OFS_ALTSTAT: rdata_d = status_w;
         `ACA_OFS_SECCNT: rdata_d = sc_q;
         `ACA_OFS_ERROR: rdata_d = err_q;
         `ACA_OFS_DRVHEAD: rdata_d = dh_q;
         `ACA_OFS_DRVADDR: begin
            rdata_d[7] = 1'b0;
            rdata_d[`ACA_RB_WGATE] = ~wg_w;
            rdata_d[`ACA_RB_HEAD_HI:`ACA_RB_HEAD_LO] = ~dh_q[`ACA_DH_HEAD_HI:0];
            rdata_d[`ACA_RB_DS1] = ~(drive_id_in && selected(dh_q, drive_id_in));
            rdata_d[`ACA_RB_DS0] = ~(!drive_id_in && selected(dh_q, drive_id_in));
         end
         default: rdata_d = 8'h00;
      endcase
   end

   // Registers only; clock enable freezes everything
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state_q <= ACA_ST_IDLE;
         op_q <= ACA_OP_PLAIN;
         cnt_q <= '0;
         dh_q <= `ACA_RST_DRVHEAD;
         sc_q <= `ACA_RST_SECCNT;
         err_q <= `ACA_RST_ERROR;
         code_q <= 8'h00;
         head_q <= 4'h0;
         start_q <= 1'b0;
         int_q <= 1'b0;
         errf_q <= 1'b0;
         rdata_q <= 8'h00;
         busy_q <= 1'b0;
         drq_q <= 1'b0;
         wg_q <= 1'b0;
      end else if (ce_in) begin
         state_q <= state_d;
         op_q <= op_d;
         cnt_q <= cnt_d;
         dh_q <= dh_d;
         sc_q <= sc_d;
         err_q <= err_d;
         code_q <= code_d;
         head_q <= head_d;
         start_q <= start_d;
         int_q <= int_d;
         errf_q <= errf_d;
         rdata_q <= rdata_d;
         busy_q <= busy_d;
         drq_q <= drq_d;
         wg_q <= wg_d;
      end
   end

   assign rdata_out = rdata_q;
   assign busy_out = busy_w;
   assign drq_out = drq_w;
   assign intrq_out = int_q;
   assign cmd_start_out = start_q;
   assign cmd_code_out = code_q;
   assign head_out = head_q;
   assign wgate_out = wg_w;
endmodule

// *** tb/aca_core_monitor.sv ***
// Assertion checker for the command acceptance block
`timescale 1ns/10ps
module aca_core_monitor (
   input wire logic clk_in, // Clock
   input wire logic arst_n_in, // Reset
   input wire logic ce_in, // Enable
   input wire logic [3:0] addr_in, // Offset
   input wire logic wr_in, // Write
   input wire logic rd_in, // Read
   input wire logic [7:0] rdata_out, // Read data
   input wire logic busy_out, // Busy
   input wire logic drq_out, // Data request
   input wire logic intrq_out, // Interrupt
   input wire logic cmd_start_out, // Start pulse
   input wire logic [7:0] cmd_code_out, // Code
   input wire logic wgate_out // Write active
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   // Readback register read
   sequence seq_rb_rd;
      ce_in && rd_in && addr_in == 4'hF;
   endsequence
   // Power query answered and interrupt raised
   sequence seq_pwr_end;
      !busy_out && intrq_out;
   endsequence
   chk_rb_wgate: assert property (seq_rb_rd |=> rdata_out[6] == !$past(wgate_out))
      else $error("readback write bit wrong");
   chk_one_drive: assert property (seq_rb_rd |=> rdata_out[1:0] != 2'b00)
      else $error("both drive bits low");
   chk_start_busy: assert property (cmd_start_out |-> busy_out)
      else $error("start without busy");
   chk_start_pulse: assert property (cmd_start_out |=> !cmd_start_out)
      else $error("start pulse too long");
   chk_drq_drop: assert property ($rose(drq_out) |-> ##[0:50] !busy_out)
      else $error("busy held after data request");
   chk_drq_excl: assert property (drq_out |-> !busy_out)
      else $error("data request while busy");
   chk_stat_clear: assert property (ce_in && rd_in && addr_in == 4'h7 && !busy_out |=> !intrq_out)
      else $error("status read left interrupt");
   chk_alt_keep: assert property (ce_in && rd_in && addr_in == 4'hE && intrq_out |=> intrq_out)
      else $error("alternate read cleared interrupt");
   chk_pwr_seq: assert property (cmd_start_out && cmd_code_out inside {8'hE5, 8'h98} |-> ##2 seq_pwr_end)
      else $error("power query sequence wrong");
endmodule
bind aca_core aca_core_monitor mon (.clk_in(clk_in), .arst_n_in(arst_n_in), .ce_in(ce_in), .addr_in(addr_in),
   .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .busy_out(busy_out), .drq_out(drq_out),
   .intrq_out(intrq_out), .cmd_start_out(cmd_start_out), .cmd_code_out(cmd_code_out), .wgate_out(wgate_out));

// *** tb/aca_host_model.sv ***
// Host bus controller model driving the task-file strobes
`timescale 1ns/10ps
module aca_host_model (
   input wire logic clk_in, // Clock
   output logic [3:0] addr_out, // Offset
   output logic wr_out, // Write strobe
   output logic rd_out, // Read strobe
   output logic [7:0] wdata_out // Write data
);
   initial begin
      addr_out = 4'h0;
      wr_out = 1'b0;
      rd_out = 1'b0;
      wdata_out = 8'h00;
   end
   // One strobe cycle; callers write the command last and only when idle
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_in);
      #1;
      addr_out = a;
      wdata_out = d;
      wr_out = 1'b1;
      @(posedge clk_in);
      #1;
      wr_out = 1'b0;
      wdata_out = ~d; // Released bus shows no stale value
   endtask
   // Read strobe; data is registered at the strobe edge
   // Readback offset is touched only by checks; a real host leaves it unmapped
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clk_in);
      #1;
      addr_out = a;
      rd_out = 1'b1;
      @(posedge clk_in);
      #1;
      rd_out = 1'b0;
   endtask
endmodule

// *** tb/tb.sv ***
// Self-checking testbench for the command acceptance block
`timescale 1ns/10ps
module tb;
   localparam int DRQ2 = 60; // Shortened class 2 limit
   localparam int DRQ3 = 120; // Shortened class 3 limit
   logic clk, arst_n, ce, drive_id, sleep, exec_done, xfer_done, wr, rd;
   logic busy, drq, intrq, start, wgate;
   logic [3:0] addr, head;
   logic [7:0] wdata, diag, rdata, code;
   int miscompares = 0;
   int num_checks = 0;
   int cyc = 0;
   aca_host_model host (.clk_in(clk), .addr_out(addr), .wr_out(wr), .rd_out(rd), .wdata_out(wdata));
   aca_core #(.DRQ2_CYC(DRQ2), .DRQ3_CYC(DRQ3)) dut (.clk_in(clk), .arst_n_in(arst_n), .ce_in(ce),
      .addr_in(addr), .wr_in(wr), .rd_in(rd), .wdata_in(wdata), .drive_id_in(drive_id), .sleep_in(sleep),
      .exec_done_in(exec_done), .xfer_done_in(xfer_done), .diag_code_in(diag), .rdata_out(rdata),
      .busy_out(busy), .drq_out(drq), .intrq_out(intrq), .cmd_start_out(start), .cmd_code_out(code),
      .head_out(head), .wgate_out(wgate));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         miscompares++;
         results();
      end
   end
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rdchk(input logic [3:0] a, input logic [7:0] e, input string n);
      host.rd_reg(a);
      chk(n, e, rdata);
   endtask
   // Issue one command, play the engine and host until it completes
   task automatic run_cmd(input logic [7:0] c, input int cls);
      int n;
      int at;
      at = -1;
      host.wr_reg(4'h7, c);
      chk("busy", 8'h01, {7'h0, busy});
      chk("code", c, code);
      chk("start", 8'h01, {7'h0, start});
      for (n = 0; n < DRQ3 + 200; n++) begin
         @(posedge clk);
         #1;
         if (drq && at < 0) begin
            at = n;
            chk("wgate", {7'h0, cls > 1}, {7'h0, wgate});
         end
         if (!busy && !drq && intrq) break;
         exec_done = cls == 1 && busy && !drq;
         xfer_done = drq;
      end
      exec_done = 1'b0;
      xfer_done = 1'b0;
      if (cls == 2) chk("drq2", 8'h01, {7'h0, at >= 0 && at <= DRQ2});
      if (cls == 3) chk("drq3", 8'h01, {7'h0, at >= 0 && at <= DRQ3});
      host.rd_reg(4'hE);
      chk("alt", 8'h01, {7'h0, intrq});
      host.rd_reg(4'h7);
      chk("clear", 8'h00, {7'h0, intrq});
   endtask
   task automatic t_regs();
      rdchk(4'h2, 8'h01, "seccnt");
      rdchk(4'h1, 8'h01, "error");
      rdchk(4'hF, 8'h7E, "rb_reset");
      host.wr_reg(4'h6, 8'hA5);
      rdchk(4'hF, 8'h6A, "rb_drv0");
      drive_id = 1'b1;
      host.wr_reg(4'h6, 8'hB5);
      rdchk(4'hF, 8'h69, "rb_drv1");
      drive_id = 1'b0;
      host.wr_reg(4'h6, 8'hA5);
      $display("t_regs done");
   endtask
   task automatic t_decode();
      logic [7:0] c1[] = '{8'h20, 8'h21, 8'hC4, 8'h40, 8'h41, 8'h22, 8'h23, 8'hE4, 8'h91, 8'hEC, 8'h10, 8'h1F,
         8'h70, 8'h7F, 8'hEF, 8'hC6, 8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE6, 8'h94, 8'h95, 8'h96, 8'h97, 8'h99,
         8'hC0, 8'h03, 8'h87, 8'hF5};
      logic [7:0] c2[] = '{8'h30, 8'h31, 8'h38, 8'h3C, 8'hE8, 8'h32, 8'h33, 8'h50};
      foreach (c1[i]) run_cmd(c1[i], 1);
      foreach (c2[i]) run_cmd(c2[i], 2);
      run_cmd(8'hC5, 3);
      run_cmd(8'hCD, 3);
      run_cmd(8'hEC, 1);
      chk("head_d", 8'h00, {4'h0, head});
      run_cmd(8'hC4, 1);
      chk("head_y", 8'h05, {4'h0, head});
      $display("t_decode done");
   endtask
   task automatic t_power_diag();
      logic [7:0] dc[] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h80};
      sleep = 1'b1;
      run_cmd(8'hE5, 1);
      rdchk(4'h2, 8'h00, "pwr_sleep");
      sleep = 1'b0;
      run_cmd(8'h98, 1);
      rdchk(4'h2, 8'hFF, "pwr_idle");
      foreach (dc[i]) begin
         diag = dc[i];
         run_cmd(8'h90, 1);
         rdchk(4'h1, dc[i], "diag");
      end
      $display("t_power_diag done");
   endtask
   task automatic t_refuse();
      host.wr_reg(4'h6, 8'hB5);
      host.wr_reg(4'h7, 8'h20);
      chk("unsel", 8'h00, {7'h0, busy});
      host.wr_reg(4'h6, 8'hA5);
      host.wr_reg(4'h7, 8'h00);
      chk("abort_busy", 8'h00, {7'h0, busy});
      chk("abort_irq", 8'h01, {7'h0, intrq});
      rdchk(4'h1, 8'h04, "abort_err");
      rdchk(4'h7, 8'h51, "abort_stat");
      chk("abort_int", 8'h00, {7'h0, intrq});
      ce = 1'b0;
      host.wr_reg(4'h6, 8'hB7);
      ce = 1'b1;
      rdchk(4'h6, 8'hA5, "freeze");
      $display("t_refuse done");
   endtask
   initial begin
      arst_n = 1'b0;
      ce = 1'b1;
      drive_id = 1'b0;
      sleep = 1'b0;
      exec_done = 1'b0;
      xfer_done = 1'b0;
      diag = 8'h01;
      repeat (20) @(posedge clk);
      #1;
      arst_n = 1'b1;
      t_regs();
      t_decode();
      t_power_diag();
      t_refuse();
      results();
   end
endmodule
